// ### hdl/dbsmux_pkg.sv
package dbsmux_pkg;
   // ----------------------------------------------------------------
   // Size codes (bytes still to move)
   // ----------------------------------------------------------------
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   localparam logic [1:0] SIZE_THREE = 2'h3;

   // ----------------------------------------------------------------
   // Acknowledge codes {hi, lo}, high level means asserted
   // ----------------------------------------------------------------
   localparam logic [1:0] ACK_WAIT = 2'h0;
   localparam logic [1:0] ACK_PORT8 = 2'h1;
   localparam logic [1:0] ACK_PORT16 = 2'h2;
   localparam logic [1:0] ACK_PORT32 = 2'h3;

   // ----------------------------------------------------------------
   // Operand byte indices (0 is most significant)
   // ----------------------------------------------------------------
   localparam logic [1:0] OPB_MSB = 2'h0;
   localparam logic [1:0] OPB_SECOND = 2'h1;
   localparam logic [1:0] OPB_THIRD = 2'h2;
   localparam logic [1:0] OPB_LSB = 2'h3;

   localparam int LANES = 4;
   localparam logic [1:0] RESET_OFFSET = 2'h0;
   localparam logic [31:0] RESET_DATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      DBS_IDLE,
      DBS_ACTIVE
   } dbsmux_state_type;
endpackage

// ### hdl/dbsmux_lane_if.sv
`timescale 1ns/1ps
// Per-cycle steering request shared by the write and read lane muxes
interface dbsmux_lane_if;
   logic [1:0] size;
   logic [1:0] offset;
   logic [1:0] port_ack;
   logic [31:0] operand;
   logic [31:0] bus_in;
   logic [31:0] lanes_out;
   logic [31:0] operand_out;
   logic [3:0] operand_load;

   modport ctrl (output size, offset, port_ack, operand, bus_in,
      input lanes_out, operand_out, operand_load);
   modport wr (input size, offset, operand, output lanes_out);
   modport rd (input size, offset, port_ack, bus_in,
      output operand_out, operand_load);
endinterface

// ### hdl/dbsmux_write_mux.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Write steering: operand bytes onto the four data lanes
// ------------------------------------------------------------------
module dbsmux_write_mux (
   dbsmux_lane_if.wr lane
);
   import dbsmux_pkg::*;

   // Operand byte for an operand byte index, 0 = most significant byte
   function automatic logic [7:0] opb(input logic [31:0] op,
         input logic [1:0] idx);
      opb = op[8*(3-idx) +: 8];
   endfunction

   logic [1:0] sel [LANES];

   // Byte selection per lane, top lane first
   always_comb begin
      sel = '{OPB_LSB, OPB_LSB, OPB_LSB, OPB_LSB};
      case (lane.size)
         SIZE_BYTE: sel = '{OPB_LSB, OPB_LSB, OPB_LSB, OPB_LSB};
         SIZE_WORD: begin
            if (!lane.offset[0]) begin
               sel = '{OPB_THIRD, OPB_LSB, OPB_THIRD, OPB_LSB};
            end else begin
               sel = '{OPB_THIRD, OPB_THIRD, OPB_LSB, OPB_THIRD};
            end
         end
         SIZE_THREE: begin
            case (lane.offset)
               // Bottom lane carries an unused byte
               2'h0: sel = '{OPB_SECOND, OPB_THIRD, OPB_LSB, OPB_MSB};
               2'h1: sel = '{OPB_SECOND, OPB_SECOND, OPB_THIRD, OPB_LSB};
               2'h2: sel = '{OPB_SECOND, OPB_THIRD, OPB_SECOND, OPB_THIRD};
               default: sel = '{OPB_SECOND, OPB_SECOND, OPB_THIRD, OPB_SECOND};
            endcase
         end
         default: begin
            case (lane.offset)
               2'h0: sel = '{OPB_MSB, OPB_SECOND, OPB_THIRD, OPB_LSB};
               2'h1: sel = '{OPB_MSB, OPB_MSB, OPB_SECOND, OPB_THIRD};
               2'h2: sel = '{OPB_MSB, OPB_SECOND, OPB_MSB, OPB_SECOND};
               default: sel = '{OPB_MSB, OPB_MSB, OPB_SECOND, OPB_MSB};
            endcase
         end
      endcase
   end

   // Lane 0 is D31-D24
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane
         assign lane.lanes_out[8*(3-g) +: 8] = opb(lane.operand, sel[g]);
      end
   endgenerate
endmodule // dbsmux_write_mux

// ### hdl/dbsmux_read_mux.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Read steering: received lanes into operand byte positions
// ------------------------------------------------------------------
module dbsmux_read_mux (
   dbsmux_lane_if.rd lane
);
   import dbsmux_pkg::*;

   // Bytes moved this cycle for port width, size and offset
   function automatic logic [2:0] moved(input logic [1:0] ack,
         input logic [1:0] size, input logic [1:0] off);
      logic [2:0] rem;
      logic [2:0] room;
      rem = (size == SIZE_LONG) ? 3'h4 : {1'b0, size};
      case (ack)
         ACK_PORT8: room = 3'h1;
         ACK_PORT16: room = off[0] ? 3'h1 : 3'h2;
         default: room = 3'h4 - {1'b0, off};
      endcase
      moved = (rem < room) ? rem : room;
   endfunction

   logic [2:0] rem;
   logic [2:0] n;

   // Map lanes to operand positions; position counts from the lsb end
   always_comb begin
      logic [1:0] first_lane;
      logic [2:0] pos;
      logic [2:0] ln;
      first_lane = 2'h0;
      pos = 3'h0;
      ln = 3'h0;
      rem = (lane.size == SIZE_LONG) ? 3'h4 : {1'b0, lane.size};
      n = moved(lane.port_ack, lane.size, lane.offset);
      lane.operand_out = RESET_DATA;
      lane.operand_load = 4'h0;
      case (lane.port_ack)
         ACK_PORT8: first_lane = 2'h0;
         ACK_PORT16: first_lane = {1'b0, lane.offset[0]};
         default: first_lane = lane.offset;
      endcase
      for (int k = 0; k < LANES; k++) begin
         if (k[2:0] < n) begin
            ln = {1'b0, first_lane} + k[2:0];
            pos = rem - 3'h1 - k[2:0]; // 0 = lsb byte
            lane.operand_out[8*pos[1:0] +: 8] =
               lane.bus_in[8*(3-ln[1:0]) +: 8];
            lane.operand_load[pos[1:0]] = 1'b1;
         end
      end
   end
endmodule // dbsmux_read_mux

// ### hdl/dbsmux_top.sv
`timescale 1ns/1ps
module dbsmux_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic write,
   input wire logic [1:0] start_size,
   input wire logic [1:0] start_offset,
   input wire logic [31:0] write_operand,
   input wire logic port_ack_hi,
   input wire logic port_ack_lo,
   input wire logic [31:0] data_in,
   output logic busy,
   output logic cycle_active,
   output logic remaining_size_hi,
   output logic remaining_size_lo,
   output logic byte_offset_hi,
   output logic byte_offset_lo,
   output logic [31:0] data_out,
   output logic data_oe,
   output logic done,
   output logic [31:0] read_operand
);
   import dbsmux_pkg::*;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] ack_meta;
   logic [1:0] ack_sync;
   logic [31:0] data_meta;
   logic [31:0] data_sync;

   // Two stages for acknowledge lines and incoming data
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_meta <= ACK_WAIT;
         ack_sync <= ACK_WAIT;
         data_meta <= RESET_DATA;
         data_sync <= RESET_DATA;
      end else begin
         ack_meta <= {port_ack_hi, port_ack_lo};
         ack_sync <= ack_meta;
         data_meta <= data_in;
         data_sync <= data_meta;
      end
   end

   // ---------------------------------------------------------------
   // Transfer state
   // ---------------------------------------------------------------
   dbsmux_state_type state;
   logic is_write;
   logic [1:0] size;
   logic [1:0] offset;
   logic [31:0] operand;
   logic [31:0] gathered;
   logic [2:0] rem;
   logic [2:0] step;
   logic [2:0] next_rem;
   logic [1:0] next_offset;
   logic [1:0] next_size;
   logic acked;
   logic ack_armed;

   dbsmux_lane_if lane ();

   assign lane.size = size;
   assign lane.offset = offset;
   assign lane.port_ack = ack_sync;
   assign lane.operand = operand;
   assign lane.bus_in = data_sync;

   dbsmux_write_mux u_wr (
      .lane(lane)
   );

   dbsmux_read_mux u_rd (
      .lane(lane)
   );

   // Synchronised ack lags the pin by two cycles, so one acknowledge is
   // taken once; a new one counts only after the lines return to wait
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ack_armed <= 1'b1;
      end else if (acked) begin
         ack_armed <= 1'b0;
      end else if (ack_sync == ACK_WAIT) begin
         ack_armed <= 1'b1;
      end
   end

   // Any width code other than wait terminates the cycle
   assign acked = (state == DBS_ACTIVE) && ack_armed
      && (ack_sync != ACK_WAIT);

   // Bytes moved by this acknowledge
   always_comb begin
      rem = (size == SIZE_LONG) ? 3'h4 : {1'b0, size};
      case (ack_sync)
         ACK_PORT8: step = 3'h1;
         ACK_PORT16: step = offset[0] ? 3'h1 : 3'h2;
         default: step = 3'h4 - {1'b0, offset};
      endcase
      if (step > rem) begin
         step = rem;
      end
      next_rem = rem - step;
      next_offset = offset + step[1:0];
      next_size = next_rem[1:0]; // 4 wraps to long code
   end

   // Cycle sequencing
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state <= DBS_IDLE;
         size <= SIZE_LONG;
         offset <= RESET_OFFSET;
         is_write <= 1'b0;
         operand <= RESET_DATA;
      end else begin
         case (state)
            DBS_IDLE: begin
               if (start) begin
                  // Full size first; port width unknown yet
                  state <= DBS_ACTIVE;
                  size <= start_size;
                  offset <= start_offset;
                  is_write <= write;
                  operand <= write_operand;
               end
            end
            DBS_ACTIVE: begin
               if (acked) begin
                  if (next_rem == 3'h0) begin
                     state <= DBS_IDLE;
                  end else begin
                     // Further cycle for leftover bytes
                     size <= next_size;
                     offset <= next_offset;
                  end
               end
            end
            default: state <= DBS_IDLE;
         endcase
      end
   end

   // Read assembly of received bytes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         gathered <= RESET_DATA;
      end else if (state == DBS_IDLE && start) begin
         gathered <= RESET_DATA;
      end else if (acked && !is_write) begin
         for (int b = 0; b < LANES; b++) begin
            if (lane.operand_load[b]) begin
               gathered[8*b +: 8] <= lane.operand_out[8*b +: 8];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered pin outputs
   // ---------------------------------------------------------------
   logic going;
   logic [1:0] out_size;
   logic [1:0] out_offset;

   always_comb begin
      going = 1'b0;
      out_size = size;
      out_offset = offset;
      if (state == DBS_IDLE && start) begin
         going = 1'b1;
         out_size = start_size;
         out_offset = start_offset;
      end else if (state == DBS_ACTIVE && !(acked && next_rem == 3'h0)) begin
         going = 1'b1;
         if (acked) begin
            out_size = next_size;
            out_offset = next_offset;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         busy <= 1'b0;
         cycle_active <= 1'b0;
         remaining_size_hi <= 1'b0;
         remaining_size_lo <= 1'b0;
         byte_offset_hi <= 1'b0;
         byte_offset_lo <= 1'b0;
      end else begin
         busy <= going;
         cycle_active <= going && !acked;
         remaining_size_hi <= out_size[1];
         remaining_size_lo <= out_size[0];
         byte_offset_hi <= out_offset[1];
         byte_offset_lo <= out_offset[0];
      end
   end

   // Write lanes follow current size and offset; bus driven in writes
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         data_out <= RESET_DATA;
         data_oe <= 1'b0;
      end else begin
         data_out <= lane.lanes_out;
         data_oe <= (state == DBS_ACTIVE) && is_write;
      end
   end

   // Completion pulse and read result
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         done <= 1'b0;
         read_operand <= RESET_DATA;
      end else begin
         done <= acked && (next_rem == 3'h0);
         if (acked && next_rem == 3'h0 && !is_write) begin
            read_operand <= gathered;
            for (int b = 0; b < LANES; b++) begin
               if (lane.operand_load[b]) begin
                  read_operand[8*b +: 8] <= lane.operand_out[8*b +: 8];
               end
            end
         end
      end
   end
endmodule // dbsmux_top

// ### bench/dbsmux_top_sva.sv
`timescale 1ns/1ps
module dbsmux_top_sva
   import dbsmux_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic write,
   input wire logic [1:0] start_size,
   input wire logic [1:0] start_offset,
   input wire logic [31:0] write_operand,
   input wire logic port_ack_hi,
   input wire logic port_ack_lo,
   input wire logic busy,
   input wire logic remaining_size_hi,
   input wire logic remaining_size_lo,
   input wire logic byte_offset_hi,
   input wire logic byte_offset_lo,
   input wire logic [31:0] data_out,
   input wire logic data_oe,
   input wire logic done
);
   logic [31:0] op;
   logic [31:0] lanes;
   logic [7:0] idx;
   logic [1:0] sz;
   logic [1:0] off;
   assign sz = {remaining_size_hi, remaining_size_lo};
   assign off = {byte_offset_hi, byte_offset_lo};
   // Operand held from the accepted start
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         op <= 32'h0;
      end else if (start && !busy) begin
         op <= write_operand;
      end
   end
   // Expected lanes: operand byte index per lane, top lane first
   always_comb begin
      case ({sz, off})
         4'h0: idx = 8'h1b;
         4'h1: idx = 8'h06;
         4'h2: idx = 8'h11;
         4'h3: idx = 8'h04;
         4'h8, 4'ha: idx = 8'hbb;
         4'h9, 4'hb: idx = 8'hae;
         4'hc: idx = 8'h6c;
         4'hd: idx = 8'h5b;
         4'he: idx = 8'h66;
         4'hf: idx = 8'h59;
         default: idx = 8'hff;
      endcase
      for (int i = 0; i < 4; i++) begin
         lanes[31 - 8 * i -: 8] = op[31 - 8 * idx[7 - 2 * i -: 2] -: 8];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_lane_table: assert property (
      busy && $past(busy) && $stable({sz, off}) && data_oe
      |-> data_out == lanes) else $error("write lanes off table");
   chk_first_cycle: assert property (
      start && !busy |=> busy && sz == $past(start_size)
      && off == $past(start_offset)) else $error("first size wrong");
   chk_long_aligned: assert property (
      start && !busy && write && start_size == SIZE_LONG
      && start_offset == 2'h0 |-> ##3 data_out == $past(write_operand, 3))
      else $error("aligned long not on all lanes");
   chk_full_width: assert property (
      busy && sz == SIZE_LONG && off == 2'h0 && port_ack_hi && port_ack_lo
      |-> ##[1:5] done) else $error("full ack did not finish");
   chk_word_second: assert property (
      busy && sz == SIZE_LONG && off == 2'h0 && port_ack_hi && !port_ack_lo
      |-> ##[1:5] sz == SIZE_WORD && off == 2'h2)
      else $error("second half code wrong");
   chk_byte_word: assert property (
      busy && sz == SIZE_WORD && off == 2'h0 && !port_ack_hi && port_ack_lo
      |-> ##[1:5] sz == SIZE_BYTE && off == 2'h1)
      else $error("byte port word step wrong");
   chk_wait_hold: assert property (
      (busy && !port_ack_hi && !port_ack_lo) [*5]
      |-> $stable({sz, off}) && !done) else $error("moved without ack");
   chk_done_single: assert property (
      done |=> !done) else $error("done longer than a cycle");
endmodule // dbsmux_top_sva
bind dbsmux_top dbsmux_top_sva chk (.clk, .reset_n, .start, .write,
   .start_size, .start_offset, .write_operand, .port_ack_hi, .port_ack_lo,
   .busy, .remaining_size_hi, .remaining_size_lo, .byte_offset_hi,
   .byte_offset_lo, .data_out, .data_oe, .done);

// ### bench/dbsmux_port_model.sv
`timescale 1ns/1ps
module dbsmux_port_model
   import dbsmux_pkg::*;
(
   input wire logic clk,
   input wire logic [1:0] width,
   input wire logic [1:0] dly,
   input wire logic [7:0] seed,
   input wire logic start,
   input wire logic busy,
   input wire logic cycle_active,
   input wire logic [3:0] code,
   input wire logic [31:0] data_out,
   input wire logic data_oe,
   input wire logic done,
   output logic port_ack_hi,
   output logic port_ack_lo,
   output logic [31:0] data_in
);
   logic [7:0] mem [0:7];
   logic [3:0] seq [0:7];
   logic [3:0] lat;
   logic [2:0] addr = 3'h0;
   logic hold = 1'b0;
   int n_acks = 0;
   int cnt = 0;
   int n = 0;
   int rem;
   int room;
   // Lane carrying the k-th byte of this cycle on a fixed port wiring
   function automatic int lane_of(int k);
      if (width == ACK_PORT32) return code[1:0] + k;
      if (width == ACK_PORT16) return code[0] + k;
      return 0;
   endfunction
   // Fresh memory pattern for each accepted transfer
   always @(posedge clk) begin
      if (start && !busy) begin
         n_acks = 0;
         for (int i = 0; i < 8; i++) mem[i] = 8'(seed + 8'h25 * i);
      end
   end
   // Acknowledge after a wait, release once the cycle moves on
   initial data_in = 32'h0;
   always @(negedge clk) begin
      data_in = ~data_in; // Unused lanes never hold a stale value
      if (hold && (code != lat || done || !busy)) begin
         hold = 1'b0;
         cnt = 0;
         addr = addr + 3'(n);
      end else if (!hold && busy && cycle_active) begin
         cnt++;
         if (cnt > dly + 1) begin
            rem = (code[3:2] == SIZE_LONG) ? 4 : code[3:2];
            room = (width == ACK_PORT32) ? 4 - code[1:0] :
               (width == ACK_PORT16) ? 2 - code[0] : 1;
            n = (rem < room) ? rem : room;
            if (n_acks == 0) addr = {1'b0, code[1:0]};
            seq[n_acks] = code;
            n_acks++;
            lat = code;
            hold = 1'b1;
            for (int k = 0; k < n; k++)
               if (data_oe) mem[addr + k] = data_out[31 - 8 * lane_of(k) -: 8];
         end
      end
      if (hold && !data_oe)
         for (int k = 0; k < n; k++)
            data_in[31 - 8 * lane_of(k) -: 8] = mem[addr + k];
      {port_ack_hi, port_ack_lo} = hold ? width : ACK_WAIT;
   end
endmodule // dbsmux_port_model

// ### bench/dbsmux_top_tb_top.sv
`timescale 1ns/1ps
module dbsmux_top_tb_top;
   import dbsmux_pkg::*;
   logic clk, reset_n, start, write, port_ack_hi, port_ack_lo, busy;
   logic cycle_active, data_oe, done, remaining_size_hi, remaining_size_lo;
   logic byte_offset_hi, byte_offset_lo;
   logic [1:0] start_size, start_offset, width, dly;
   logic [31:0] write_operand, data_in, data_out, read_operand;
   logic [7:0] seed;
   int failures = 0;
   int n_checks = 0;
   dbsmux_top dut (.clk, .reset_n, .start, .write, .start_size, .start_offset,
      .write_operand, .port_ack_hi, .port_ack_lo, .data_in, .busy,
      .cycle_active, .remaining_size_hi, .remaining_size_lo, .byte_offset_hi,
      .byte_offset_lo, .data_out, .data_oe, .done, .read_operand);
   dbsmux_port_model model (.clk, .width, .dly, .seed, .start, .busy,
      .cycle_active, .code({remaining_size_hi, remaining_size_lo,
      byte_offset_hi, byte_offset_lo}), .data_out, .data_oe, .done,
      .port_ack_hi, .port_ack_lo, .data_in);
   // Compare one value and count the result
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One transfer; poke retries start while busy, which must be ignored
   task automatic run_xfer(logic [1:0] w, logic [1:0] s, logic [1:0] o,
         logic wr, logic poke);
      logic [31:0] op;
      logic [2:0] a;
      int rem, room, k, nb, i;
      seed++;
      op = 32'h8c4a_19e6 ^ {4{seed}};
      repeat (3) @(negedge clk);
      width = w;
      dly = s + o;
      {start, write, start_size, start_offset} = {1'b1, wr, s, o};
      write_operand = op;
      @(negedge clk);
      start = 1'b0;
      if (poke) begin
         @(negedge clk);
         {start, write, start_size, start_offset} = {1'b1, ~wr, ~s, ~o};
         @(negedge clk);
         start = 1'b0;
      end
      for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk);
      cmp("done", 32'h1, done);
      nb = (s == SIZE_LONG) ? 4 : s;
      rem = nb;
      a = {1'b0, o};
      for (k = 0; rem > 0 && k < 8; k++) begin
         cmp("size/offset", {2'(rem), a[1:0]}, model.seq[k]);
         room = (w == ACK_PORT32) ? 4 - a[1:0] : (w == ACK_PORT16) ? 2 - a[0] : 1;
         room = (rem < room) ? rem : room;
         rem -= room;
         a += 3'(room);
      end
      cmp("cycles", 32'(k), 32'(model.n_acks));
      for (i = 0; i < nb; i++) begin
         if (wr) cmp("port byte", op[8 * (nb - 1 - i) +: 8], model.mem[o + i]);
         else cmp("read byte", model.mem[o + i], read_operand[8 * (nb - 1 - i) +: 8]);
      end
      if (wr) cmp("spare byte", 8'(seed + 8'h25 * (o + nb)), model.mem[o + nb]);
   endtask
   // Every size and offset written to each port width
   task automatic test_write_all();
      for (int w = 1; w < 4; w++)
         for (int s = 0; s < 4; s++)
            for (int o = 0; o < 4; o++) run_xfer(2'(w), 2'(s), 2'(o), 1'b1, 1'b0);
   endtask
   // Every size and offset read, with a refused start on the diagonal
   task automatic test_read_all();
      for (int w = 1; w < 4; w++)
         for (int s = 0; s < 4; s++)
            for (int o = 0; o < 4; o++) run_xfer(2'(w), 2'(s), 2'(o), 1'b0, s == o);
   endtask
   // Reset in mid transfer clears outputs, then a clean transfer follows
   task automatic test_reset_midrun();
      @(negedge clk);
      {width, dly} = {ACK_PORT8, 2'h3};
      {start, write, start_size, start_offset} = {1'b1, 1'b1, SIZE_LONG, 2'h0};
      @(negedge clk);
      start = 1'b0;
      repeat (6) @(negedge clk);
      reset_n = 1'b0;
      repeat (3) @(negedge clk);
      cmp("flags in reset", 32'h0, {26'h0, busy, done, data_oe,
         cycle_active, remaining_size_hi, byte_offset_hi});
      cmp("data_out in reset", 32'h0, data_out);
      reset_n = 1'b1;
      run_xfer(ACK_PORT16, SIZE_LONG, 2'h0, 1'b1, 1'b1);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {reset_n, start, write, start_size, start_offset, width, dly} = '0;
      write_operand = 32'h0;
      seed = 8'h0;
      repeat (10) @(negedge clk);
      reset_n = 1'b1;
      test_write_all();
      test_read_all();
      test_reset_midrun();
      final_report();
   end
   // Watchdog against a hung handshake
   initial begin
      #300us;
      failures++;
      final_report();
   end
endmodule // dbsmux_top_tb_top
